// ---- sim/far_side_model.sv ----
// Behavioural model of the cores, graphics engine and cache flush status.
`timescale 1ns/1ps
module far_side_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        m_set,
  input  wire logic        m_gfx,
  input  wire logic [11:0] m_cs,
  input  wire logic [3:0]  m_fl,
  input  wire logic        m_llc,
  output logic             gfx_render_sleep,
  output logic [11:0]      core_state,
  output logic [3:0]       save_memory_flushed,
  output logic             llc_flushed
);
  // The agents post a new idle picture together, on the edge it is set.
  always_ff @(posedge aclk) begin
    if (!aresetn)
      {gfx_render_sleep, core_state, save_memory_flushed, llc_flushed} <= '0;
    else if (m_set)
      {gfx_render_sleep, core_state, save_memory_flushed, llc_flushed} <=
        {m_gfx, m_cs, m_fl, m_llc};
  end
endmodule

// ---- sim/tb_package_idle_state_resolver.sv ----
// Self-checking bench for the package idle state resolver.
`timescale 1ns/1ps
module tb_package_idle_state_resolver;
  typedef struct {
    logic [31:0] e;
    logic [31:0] m;
    logic [1:0]  r;
  } note_s;
  note_s       wq[$], rq[$], wn, rn;
  int          err_total, checks_done;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0]  wstrb, save_memory_flushed, m_fl, pkg_target;
  logic [1:0]  bresp, rresp;
  logic [11:0] core_state, m_cs;
  logic [9:0]  dsp;
  logic [5:0]  wl;
  logic [6:0]  disp_level;
  logic [2:0]  pipe_req, pipe_power;
  logic        m_set, m_gfx, m_llc, gfx_render_sleep, llc_flushed;
  logic        display_req_pending, io_mem_traffic, display_idle, sa_idle;
  logic        panel_self_refresh, ext_display, scaling_on, mem_self_refresh;
  logic        ext_well_on, int_well_on, io_power_on, main_power_on;
  logic        latency_tolerance_report, ltr_at_max;
  logic        refresh_traffic_compression;

  // Display inputs are packed so one assignment moves them together.
  assign {pipe_req, scaling_on, ext_display, panel_self_refresh, sa_idle,
          display_idle, io_mem_traffic, display_req_pending} = dsp;

  pkg_idle_state_resolver i_pkg_idle_state_resolver (.*);
  far_side_model i_far_side_model (.*);

  // Free-running 50 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and result checking
  // ----------------------------------------------------------------
  task automatic cmp(input string nm, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Write: both channels offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic pa, pw;
    wq.push_back('{32'h0, 32'h0, r});
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid} <= 2'h3;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
  endtask

  // Read: the monitor compares the masked data when it arrives.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input logic [1:0] r);
    rq.push_back('{e, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
  endtask

  // One idle case, v = {g,deeper,llc,-}{min core}{flushed}{en}{limit}{exp}.
  task automatic step(input logic [23:0] v);
    logic [11:0] cs;
    for (int i = 0; i < 4; i++)
      cs[3*i+:3] = v[22] && i > 0 ?
        v[18:16] + 3'($urandom_range(6 - v[18:16])) : v[18:16];
    wr(pkg_idle_pkg::CTRL_OFS, {20'h0, 8'h18, v[7:4]}, 2'h0);
    wr(pkg_idle_pkg::CORE_EN_OFS, {28'h0, v[11:8]}, 2'h0);
    {m_gfx, m_cs, m_fl, m_llc, m_set} <= {v[23], cs, v[15:12], v[21], 1'b1};
    @(posedge aclk);
    m_set <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(pkg_idle_pkg::STATUS_OFS, {20'h0, v[23] && v[3:0] >=
       pkg_idle_pkg::PKG_LEVEL_3, 7'h0, v[3:0]}, 32'h80f, 2'h0);
  endtask

  // Display case: set inputs, let the levels settle, read the status.
  task automatic dstep(input logic [9:0] d, input logic [31:0] e, m);
    dsp <= d;
    repeat (4) @(posedge aclk);
    rd(pkg_idle_pkg::STATUS_OFS, e, m, pkg_idle_pkg::RESP_OKAY);
  endtask

  // Takes the oldest note off its queue whenever a response shows up.
  always @(posedge aclk) begin
    if (aresetn && bvalid && bready) begin
      wn = wq.pop_front();
      cmp("bresp", {30'h0, wn.r}, {30'h0, bresp});
    end
    if (aresetn && rvalid && rready) begin
      rn = rq.pop_front();
      cmp("rresp", {30'h0, rn.r}, {30'h0, rresp});
      cmp("rdata", rn.e, rdata & rn.m);
      if (rn.m == 32'h80f) begin
        cmp("pkg_target", {28'h0, rn.e[3:0]}, {28'h0, pkg_target});
        cmp("mem_self_refresh", {31'h0, rn.e[11]},
            {31'h0, mem_self_refresh});
      end
      // Wells and level pins follow the display level read in the status.
      if (rn.m == 32'h7f0) begin
        wl = rn.e[4] ? 6'h3c : rn.e[5] ? 6'h3e : rn.e[6] ? 6'h1e :
             rn.e[7] ? 6'h17 : rn.e[9] ? 6'h07 : 6'h03;
        cmp("disp_level", {25'h0, rn.e[10:4]},
            {25'h0, disp_level});
        cmp("wells", {26'h0, wl}, {26'h0, ext_well_on, int_well_on,
            io_power_on, main_power_on, latency_tolerance_report,
            ltr_at_max});
      end
      if (rn.m == 32'h71000) begin
        cmp("pipe_power", {29'h0, rn.e[18:16]},
            {29'h0, pipe_power});
        cmp("refresh_traffic_compression", {31'h0, rn.e[12]},
            {31'h0, refresh_traffic_compression});
      end
    end
  end

  // Watchdog: the whole sequence needs only a few hundred cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, arvalid, m_set, m_gfx, m_llc} <= '0;
    {awaddr, araddr, wdata, m_cs, m_fl, dsp} <= '0;
    {wstrb, bready, rready} <= 6'h3f;
    void'($urandom(32'h89bf));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(pkg_idle_pkg::CTRL_OFS, pkg_idle_pkg::CTRL_RESET, '1, 2'h0);
    rd(pkg_idle_pkg::CORE_EN_OFS, 32'hf, '1, 2'h0);
    dstep(10'h0a0, 32'h010, 32'h7f0);
    rnd = $urandom & 32'h1ff;
    wr(pkg_idle_pkg::CTRL_OFS, rnd, 2'h0);
    rd(pkg_idle_pkg::CTRL_OFS, rnd, 32'h1ff, 2'h0);
    wr(8'h0c, '1, pkg_idle_pkg::RESP_SLVERR);
    rd(8'h0c, 32'h0, '1, pkg_idle_pkg::RESP_SLVERR);
    wr(pkg_idle_pkg::STATUS_OFS, '1, pkg_idle_pkg::RESP_OKAY);
    $display("Register test done");
    step(24'h42ff80);
    step(24'hc1ff80);
    step(24'hc2ff00);
    step(24'hc2ff11);
    step(24'he2ff22);
    step(24'h82ff83);
    step(24'hc2ff33);
    step(24'h83ff84);
    step(24'hc3ff44);
    step(24'ha3ff85);
    step(24'he3ff45);
    step(24'h84ff86);
    step(24'he4ff66);
    step(24'hc5ff77);
    step(24'h86ff88);
    step(24'h86bf87);
    step(24'h86bb88);
    $display("Target test done");
    wr(pkg_idle_pkg::CTRL_OFS, 32'h190, 2'h0);
    dstep(10'h0a0, 32'h020, 32'h7f0);
    dstep(10'h080, 32'h040, 32'h7f0);
    dstep(10'h090, 32'h080, 32'h7f0);
    dstep(10'h084, 32'h200, 32'h7f0);
    dstep(10'h08c, 32'h400, 32'h7f0);
    wr(pkg_idle_pkg::CTRL_OFS, 32'h1f0, 2'h0);
    dstep(10'h0a0, 32'h11000, 32'h71000);
    dstep(10'h1a0, 32'h70000, 32'h71000);
    dstep(10'h0e0, 32'h71000, 32'h71000);
    $display("Display test done");
    report_and_stop;
  end
endmodule

// ---- verilog/pkg_idle_pkg.sv ----
// Shared encodings, register map and reset values for the idle resolver.
package pkg_idle_pkg;
  // Core idle levels, ordered shallow to deep.
  localparam logic [2:0] CORE_LEVEL_0  = 3'h0;
  localparam logic [2:0] CORE_LEVEL_1  = 3'h1;
  localparam logic [2:0] CORE_LEVEL_6  = 3'h2;
  localparam logic [2:0] CORE_LEVEL_7  = 3'h3;
  localparam logic [2:0] CORE_LEVEL_8  = 3'h4;
  localparam logic [2:0] CORE_LEVEL_9  = 3'h5;
  localparam logic [2:0] CORE_LEVEL_10 = 3'h6;
  // Package idle targets, ordered shallow to deep.
  localparam logic [3:0] PKG_ACTIVE          = 4'h0;
  localparam logic [3:0] PKG_LEVEL_2         = 4'h1;
  localparam logic [3:0] PKG_LEVEL_3         = 4'h2;
  localparam logic [3:0] PKG_LEVEL_6         = 4'h3;
  localparam logic [3:0] PKG_LEVEL_7         = 4'h4;
  localparam logic [3:0] PKG_LEVEL_7_FLUSHED = 4'h5;
  localparam logic [3:0] PKG_LEVEL_8         = 4'h6;
  localparam logic [3:0] PKG_LEVEL_9         = 4'h7;
  localparam logic [3:0] PKG_LEVEL_10        = 4'h8;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] CORE_EN_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  // Control register fields and reset value.
  localparam int CTRL_LIMIT_LSB  = 0;
  localparam int CTRL_DRIVER_BIT = 4;
  localparam int CTRL_COMP_BIT   = 5;
  localparam int CTRL_PIPE_BIT   = 6;
  localparam int CTRL_SR_BIT     = 7;
  localparam int CTRL_GFX_BIT    = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0188;
  // Status register fields.
  localparam int ST_TARGET_LSB = 0;
  localparam int ST_DISP_LSB   = 4;
  localparam int ST_SR_BIT     = 11;
  localparam int ST_COMP_BIT   = 12;
  localparam int ST_PIPE_LSB   = 16;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Display power levels.
  typedef enum logic [6:0] {
    DISP_LEVEL_0 = 7'h01,
    DISP_LEVEL_1 = 7'h02,
    DISP_LEVEL_2 = 7'h04,
    DISP_LEVEL_3 = 7'h08,
    DISP_LEVEL_4 = 7'h10,
    DISP_LEVEL_5 = 7'h20,
    DISP_LEVEL_6 = 7'h40
  } disp_state_e;
endpackage

// ---- verilog/pkg_idle_state_resolver.sv ----
// Package idle resolver with display power control and AXI4-Lite registers.
// Summary of operation
// - Active graphics, any enabled core at level 0 or 1, or active limit -> active.
// - Graphics asleep, cores at level 6 or deeper, limit level 2 -> level 2.
// - Graphics asleep, cores at level 6 or deeper, limit level 3 -> level 3.
// - Graphics asleep, cores at level 6 and limit allowing it -> level 6.
// - Same for level 7 while the cache is not fully flushed.
// - Level 7 conditions with a fully flushed cache select flushed level 7.
// - Cores at level 8 and limit allowing it give package level 8.
// - Cores at level 9 and limit allowing it give package level 9.
// - Level 10 needs all enabled cores flushed, otherwise level 9.
// - At package level 3 or deeper, memory may enter self-refresh.
// - Display level 0 and 1 keep all wells on; level 1 allows latency.
// - Level 2 drops external wells; level 3 also turns I/O off.
// - Idle display passes transition level 4 before reaching level 5.
// - Display level 6 only when display and system agent are idle.
// - Refresh traffic compression only with a single active pipe.
// - Single display without scaling powers off all inactive pipes.
`timescale 1ns/1ps
module pkg_idle_state_resolver #(
  parameter int NCORE = 4,
  parameter int NPIPE = 3
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire logic               gfx_render_sleep,
  input  wire logic [NCORE*3-1:0] core_state,
  input  wire logic [NCORE-1:0]   save_memory_flushed,
  input  wire logic               llc_flushed,
  input  wire logic               display_req_pending,
  input  wire logic               io_mem_traffic,
  input  wire logic               display_idle,
  input  wire logic               sa_idle,
  input  wire logic               panel_self_refresh,
  input  wire logic               ext_display,
  input  wire logic [NPIPE-1:0]   pipe_req,
  input  wire logic               scaling_on,
  output logic [3:0]              pkg_target,
  output logic                    mem_self_refresh,
  output logic [6:0]              disp_level,
  output logic                    ext_well_on,
  output logic                    int_well_on,
  output logic                    io_power_on,
  output logic                    main_power_on,
  output logic                    latency_tolerance_report,
  output logic                    ltr_at_max,
  output logic                    refresh_traffic_compression,
  output logic [NPIPE-1:0]        pipe_power
);
  typedef struct packed {
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    aw_got;
    logic                    w_got;
    logic [7:0]              awaddr;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
    logic [31:0]             ctrl;
    logic [NCORE-1:0]        core_en;
    logic [3:0]              target;
    pkg_idle_pkg::disp_state_e disp;
    logic                    sr;
    logic                    comp;
    logic [NPIPE-1:0]        pipe_pwr;
    logic                    ext_well;
    logic                    int_well;
    logic                    io_on;
    logic                    main_pwr;
    logic                    ltr_ok;
    logic                    ltr_max;
  } state_s;

  state_s     s_r;
  state_s     s_nxt;
  logic [3:0] target_now;
  logic [31:0] status_word;

  // --------------------------------------------------------------------
  // Target selection
  // --------------------------------------------------------------------
  // The resolver sees the live inputs and the configured limit.
  pkg_target_resolver #(.NCORE(NCORE)) u_resolver (
    .gfx_render_sleep    (gfx_render_sleep),
    .core_state          (core_state),
    .core_en             (s_r.core_en),
    .save_memory_flushed (save_memory_flushed),
    .llc_flushed         (llc_flushed),
    .limit               (s_r.ctrl[pkg_idle_pkg::CTRL_LIMIT_LSB +: 4]),
    .target              (target_now)
  );

  // Merges write data into an old word under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // --------------------------------------------------------------------
  // Read-back of the block's own state
  // --------------------------------------------------------------------
  // Status word collects target, display level and power decisions.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[pkg_idle_pkg::ST_TARGET_LSB +: 4] = s_r.target;
    status_word[pkg_idle_pkg::ST_DISP_LSB +: 7]   = s_r.disp;
    status_word[pkg_idle_pkg::ST_SR_BIT]          = s_r.sr;
    status_word[pkg_idle_pkg::ST_COMP_BIT]        = s_r.comp;
    status_word[pkg_idle_pkg::ST_PIPE_LSB +: NPIPE] = s_r.pipe_pwr;
  end

  // --------------------------------------------------------------------
  // Next state of the whole block
  // --------------------------------------------------------------------
  // Bus slave, display sequencing and power decisions in one pass.
  always_comb begin
    logic        aw_hs;
    logic        w_hs;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        gfx_ok;
    logic        single;
    aw_hs  = awvalid && s_r.awready;
    w_hs   = wvalid && s_r.wready;
    wa     = aw_hs ? awaddr : s_r.awaddr;
    wd     = w_hs ? wdata : s_r.wdata;
    ws     = w_hs ? wstrb : s_r.wstrb;
    gfx_ok = 1'b0;
    single = $onehot(pipe_req);
    s_nxt  = s_r;
    // Write channel: address and data are held until both are present.
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (aw_hs) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = awaddr;
    end
    if (w_hs) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    if (s_nxt.aw_got && s_nxt.w_got && !s_nxt.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = pkg_idle_pkg::RESP_OKAY;
      if (wa[7:2] == pkg_idle_pkg::CTRL_OFS[7:2]) begin
        s_nxt.ctrl = merge(s_r.ctrl, wd, ws);
      end else if (wa[7:2] == pkg_idle_pkg::CORE_EN_OFS[7:2]) begin
        s_nxt.core_en = NCORE'(merge(32'(s_r.core_en), wd, ws));
      end else if (wa[7:2] != pkg_idle_pkg::STATUS_OFS[7:2]) begin
        s_nxt.bresp = pkg_idle_pkg::RESP_SLVERR;
      end
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
    // Read channel: one read at a time, answered the cycle after.
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = pkg_idle_pkg::RESP_OKAY;
      if (araddr[7:2] == pkg_idle_pkg::CTRL_OFS[7:2]) begin
        s_nxt.rdata = s_r.ctrl;
      end else if (araddr[7:2] == pkg_idle_pkg::CORE_EN_OFS[7:2]) begin
        s_nxt.rdata = 32'(s_r.core_en);
      end else if (araddr[7:2] == pkg_idle_pkg::STATUS_OFS[7:2]) begin
        s_nxt.rdata = status_word;
      end else begin
        s_nxt.rdata = 32'h0000_0000;
        s_nxt.rresp = pkg_idle_pkg::RESP_SLVERR;
      end
    end
    s_nxt.arready = !s_nxt.rvalid;
    // Package target follows the inputs every cycle.
    s_nxt.target = target_now;
    // Self-refresh only in deep package levels with quiet memory users.
    if (!s_r.ctrl[pkg_idle_pkg::CTRL_GFX_BIT]) begin
      gfx_ok = 1'b1;
    end else begin
      gfx_ok = gfx_render_sleep && !display_req_pending;
    end
    s_nxt.sr = s_r.ctrl[pkg_idle_pkg::CTRL_SR_BIT] && gfx_ok &&
               !io_mem_traffic &&
               s_r.target >= pkg_idle_pkg::PKG_LEVEL_3;
    // Display level sequencing.
    if (!s_r.ctrl[pkg_idle_pkg::CTRL_DRIVER_BIT]) begin
      s_nxt.disp = pkg_idle_pkg::DISP_LEVEL_0;
    end else if (display_idle) begin
      case (s_r.disp)
        pkg_idle_pkg::DISP_LEVEL_4: begin
          s_nxt.disp = pkg_idle_pkg::DISP_LEVEL_5;
        end
        pkg_idle_pkg::DISP_LEVEL_5,
        pkg_idle_pkg::DISP_LEVEL_6: begin
          s_nxt.disp = sa_idle ? pkg_idle_pkg::DISP_LEVEL_6
                               : pkg_idle_pkg::DISP_LEVEL_5;
        end
        default: begin
          s_nxt.disp = pkg_idle_pkg::DISP_LEVEL_4;
        end
      endcase
    end else if (panel_self_refresh || pipe_req == '0) begin
      s_nxt.disp = pkg_idle_pkg::DISP_LEVEL_3;
    end else if (ext_display) begin
      s_nxt.disp = pkg_idle_pkg::DISP_LEVEL_1;
    end else begin
      s_nxt.disp = pkg_idle_pkg::DISP_LEVEL_2;
    end
    // Power wells follow the next display level so they stay aligned.
    s_nxt.ext_well = 1'b1;
    s_nxt.int_well = 1'b1;
    s_nxt.io_on    = 1'b1;
    s_nxt.main_pwr = 1'b1;
    s_nxt.ltr_ok   = 1'b0;
    s_nxt.ltr_max  = 1'b0;
    case (s_nxt.disp)
      pkg_idle_pkg::DISP_LEVEL_0: begin
        s_nxt.ltr_ok = 1'b0;
      end
      pkg_idle_pkg::DISP_LEVEL_1: begin
        s_nxt.ltr_ok = 1'b1;
      end
      pkg_idle_pkg::DISP_LEVEL_2: begin
        s_nxt.ext_well = 1'b0;
        s_nxt.ltr_ok   = 1'b1;
      end
      pkg_idle_pkg::DISP_LEVEL_3,
      pkg_idle_pkg::DISP_LEVEL_4: begin
        s_nxt.ext_well = 1'b0;
        s_nxt.io_on    = 1'b0;
        s_nxt.ltr_ok   = 1'b1;
        s_nxt.ltr_max  = 1'b1;
      end
      pkg_idle_pkg::DISP_LEVEL_5: begin
        s_nxt.ext_well = 1'b0;
        s_nxt.io_on    = 1'b0;
        s_nxt.int_well = 1'b0;
        s_nxt.ltr_ok   = 1'b1;
        s_nxt.ltr_max  = 1'b1;
      end
      pkg_idle_pkg::DISP_LEVEL_6: begin
        s_nxt.ext_well = 1'b0;
        s_nxt.io_on    = 1'b0;
        s_nxt.int_well = 1'b0;
        s_nxt.main_pwr = 1'b0;
        s_nxt.ltr_ok   = 1'b1;
        s_nxt.ltr_max  = 1'b1;
      end
      default: begin
        s_nxt.ltr_ok = 1'b0;
      end
    endcase
    // Pipe power and compression depend on a single active pipe.
    s_nxt.comp = s_r.ctrl[pkg_idle_pkg::CTRL_COMP_BIT] && single;
    if (s_r.ctrl[pkg_idle_pkg::CTRL_PIPE_BIT] && single && !scaling_on) begin
      s_nxt.pipe_pwr = pipe_req;
    end else begin
      s_nxt.pipe_pwr = '1;
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  // Synchronous reset to a quiet bus and a fully powered display.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r          <= '0;
      s_r.awready  <= 1'b1;
      s_r.wready   <= 1'b1;
      s_r.arready  <= 1'b1;
      s_r.ctrl     <= pkg_idle_pkg::CTRL_RESET;
      s_r.core_en  <= '1;
      s_r.disp     <= pkg_idle_pkg::DISP_LEVEL_0;
      s_r.pipe_pwr <= '1;
      s_r.ext_well <= 1'b1;
      s_r.int_well <= 1'b1;
      s_r.io_on    <= 1'b1;
      s_r.main_pwr <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign awready = s_r.awready;
  assign wready  = s_r.wready;
  assign bvalid  = s_r.bvalid;
  assign bresp   = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid  = s_r.rvalid;
  assign rresp   = s_r.rresp;
  assign rdata   = s_r.rdata;
  assign pkg_target       = s_r.target;
  assign mem_self_refresh = s_r.sr;
  assign disp_level       = s_r.disp;
  assign ext_well_on      = s_r.ext_well;
  assign int_well_on      = s_r.int_well;
  assign io_power_on      = s_r.io_on;
  assign main_power_on    = s_r.main_pwr;
  assign latency_tolerance_report    = s_r.ltr_ok;
  assign ltr_at_max                  = s_r.ltr_max;
  assign refresh_traffic_compression = s_r.comp;
  assign pipe_power                  = s_r.pipe_pwr;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  // Helpers: any enabled core shallow, all enabled cores flushed.
  logic shallow_hit;
  logic all_flushed;
  always_comb begin
    shallow_hit = 1'b0;
    all_flushed = 1'b1;
    for (int i = 0; i < NCORE; i++) begin
      if (s_r.core_en[i] &&
          core_state[i*3 +: 3] <= pkg_idle_pkg::CORE_LEVEL_1) begin
        shallow_hit = 1'b1;
      end
      if (s_r.core_en[i] && !save_memory_flushed[i]) begin
        all_flushed = 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_enter_five;
    s_r.disp != pkg_idle_pkg::DISP_LEVEL_5 ##1
    s_r.disp == pkg_idle_pkg::DISP_LEVEL_5;
  endsequence

  a_active_wins: assert property (
    (!gfx_render_sleep || shallow_hit) |=>
    s_r.target == pkg_idle_pkg::PKG_ACTIVE)
    else $error("Package target not active under an active cause.");
  a_limit_two: assert property (
    (gfx_render_sleep && !shallow_hit &&
     s_r.ctrl[3:0] == pkg_idle_pkg::PKG_LEVEL_2 &&
     $stable(s_r.ctrl)) |=> s_r.target == pkg_idle_pkg::PKG_LEVEL_2)
    else $error("Level two limit not honoured.");
  a_limit_three: assert property (
    (gfx_render_sleep && !shallow_hit &&
     s_r.ctrl[3:0] == pkg_idle_pkg::PKG_LEVEL_3 &&
     $stable(s_r.ctrl)) |=> s_r.target == pkg_idle_pkg::PKG_LEVEL_3)
    else $error("Level three limit not honoured.");
  a_plain_seven: assert property (
    s_r.target == pkg_idle_pkg::PKG_LEVEL_7 |-> !$past(llc_flushed))
    else $error("Plain level seven chosen with a flushed cache.");
  a_flush_seven: assert property (
    s_r.target == pkg_idle_pkg::PKG_LEVEL_7_FLUSHED |-> $past(llc_flushed))
    else $error("Flushed level seven chosen without a flushed cache.");
  a_deep_flush: assert property (
    s_r.target == pkg_idle_pkg::PKG_LEVEL_10 |-> $past(all_flushed))
    else $error("Level ten chosen with an unflushed core.");
  a_sr_deep: assert property (
    s_r.sr |-> $past(s_r.target) >= pkg_idle_pkg::PKG_LEVEL_3)
    else $error("Self-refresh outside a deep package level.");
  a_io_off: assert property (
    s_r.disp == pkg_idle_pkg::DISP_LEVEL_3 |-> !s_r.io_on && !s_r.ext_well)
    else $error("I/O or external wells on in display level three.");
  a_pass_transit: assert property (
    s_enter_five |-> $past(s_r.disp == pkg_idle_pkg::DISP_LEVEL_4) ||
                     $past(s_r.disp == pkg_idle_pkg::DISP_LEVEL_6))
    else $error("Display level five entered without the transition.");
  a_deepest_disp: assert property (
    s_r.disp == pkg_idle_pkg::DISP_LEVEL_6 |-> $past(sa_idle && display_idle)
    && !s_r.main_pwr)
    else $error("Display level six without both idle conditions.");
  a_single_comp: assert property (
    s_r.comp |-> $past($onehot(pipe_req)))
    else $error("Compression on without a single pipe.");
  a_one_pipe: assert property (
    (s_r.ctrl[pkg_idle_pkg::CTRL_PIPE_BIT] && $onehot(pipe_req) &&
     !scaling_on) |=> $onehot(s_r.pipe_pwr))
    else $error("More than one pipe powered in single pipe mode.");
endmodule

// ---- verilog/pkg_target_resolver.sv ----
// Combinational package idle target selection from core and graphics state.
`timescale 1ns/1ps
module pkg_target_resolver #(
  parameter int NCORE = 4
) (
  input  wire logic               gfx_render_sleep,
  input  wire logic [NCORE*3-1:0] core_state,
  input  wire logic [NCORE-1:0]   core_en,
  input  wire logic [NCORE-1:0]   save_memory_flushed,
  input  wire logic               llc_flushed,
  input  wire logic [3:0]         limit,
  output logic      [3:0]         target
);
  logic [2:0] lvl   [NCORE:0];
  logic       flush [NCORE:0];
  logic [3:0] cap;
  logic [3:0] pick;

  // Per-core chain finds the shallowest enabled core and the flush state.
  assign lvl[0]   = pkg_idle_pkg::CORE_LEVEL_10;
  assign flush[0] = 1'b1;
  for (genvar i = 0; i < NCORE; i++) begin : g_core
    logic [2:0] c;
    assign c = core_en[i] ? core_state[i*3 +: 3]
                          : pkg_idle_pkg::CORE_LEVEL_10;
    assign lvl[i+1]   = (c < lvl[i]) ? c : lvl[i];
    assign flush[i+1] = flush[i] & (save_memory_flushed[i] | ~core_en[i]);
  end

  // Deepest level the cores allow, then bounded by the limit.
  always_comb begin
    case (lvl[NCORE])
      pkg_idle_pkg::CORE_LEVEL_6:  cap = pkg_idle_pkg::PKG_LEVEL_6;
      pkg_idle_pkg::CORE_LEVEL_7:  cap = pkg_idle_pkg::PKG_LEVEL_7;
      pkg_idle_pkg::CORE_LEVEL_8:  cap = pkg_idle_pkg::PKG_LEVEL_8;
      pkg_idle_pkg::CORE_LEVEL_9:  cap = pkg_idle_pkg::PKG_LEVEL_9;
      pkg_idle_pkg::CORE_LEVEL_10: cap = flush[NCORE] ?
          pkg_idle_pkg::PKG_LEVEL_10 : pkg_idle_pkg::PKG_LEVEL_9;
      default:                     cap = pkg_idle_pkg::PKG_ACTIVE;
    endcase
    // A limit at the flushed level caps like the plain level seven.
    pick = (limit == pkg_idle_pkg::PKG_LEVEL_7_FLUSHED) ?
           pkg_idle_pkg::PKG_LEVEL_7 : limit;
    pick = (cap < pick) ? cap : pick;
    if (pick == pkg_idle_pkg::PKG_LEVEL_7 && llc_flushed) begin
      pick = pkg_idle_pkg::PKG_LEVEL_7_FLUSHED;
    end
    if (!gfx_render_sleep || lvl[NCORE] <= pkg_idle_pkg::CORE_LEVEL_1 ||
        limit == pkg_idle_pkg::PKG_ACTIVE) begin
      pick = pkg_idle_pkg::PKG_ACTIVE;
    end
    target = pick;
  end
endmodule
